// [simd_fp_exception_unit.sv]
// Exception reporting for packed floating-point operations and user interrupt dispatch.
// Assumes the datapath presents operand conditions at issue and result conditions later, one operation at a time.
//
// Behaviour
// RULE_01 - Six sticky flags, six mask bits provided.
// RULE_02 - Invalid, divide, denormal judged before computing.
// RULE_03 - Overflow, underflow, inexact judged after computing.
// RULE_04 - Masked condition: flag, default result, continue.
// RULE_05 - Unmasked with OS support: SIMD fault.
// RULE_06 - Unmasked without OS support: invalid opcode.
// RULE_07 - Fault reported on faulting instruction itself.
// RULE_08 - Unmasking an already set flag faults nothing.
// RULE_09 - Each sub-operand evaluated, all flags accumulate.
// RULE_10 - One sub-operand reports highest priority only.
// RULE_11 - Quiet NaN outranks lower conditions, unflagged.
// RULE_12 - Masked higher condition lets lower ones flag.
// RULE_13 - Fault saves faulting pointer, no error code.
// RULE_14 - Vectors 32 to 255 are user interrupts.
// RULE_15 - User interrupt saves pointer to next instruction.
// RULE_16 - External request waits for prior instructions committed.
// RULE_17 - Flags stay set until software clears them.
`timescale 1ns/10ps
`default_nettype none

module simd_fp_exception_unit #(
    parameter int unsigned IP_W = 32,
    parameter int unsigned LANES = 4
) (
    input wire logic clock,                                   // Core clock, 250 MHz.
    input wire logic srst,                                    // Synchronous reset, active high.
    input wire logic op_valid,                                // Operation issued with its operand conditions.
    input wire logic op_four_lanes,                           // High: four sub-operands, low: two.
    input wire sfeu_pkg::sfeu_pre_t [LANES-1:0] op_pre,       // Operand conditions per sub-operand.
    input wire logic [IP_W-1:0] op_ip,                        // Pointer of the issued instruction.
    input wire logic res_valid,                               // Result conditions are present.
    input wire sfeu_pkg::sfeu_post_t [LANES-1:0] res_post,    // Result conditions per sub-operand.
    input wire logic [5:0] mask_bits,                         // Mask bits of the control/status register.
    input wire logic [5:0] flag_clear,                        // Software write-clear of flags.
    input wire logic os_simd_fault_support,                   // Support bit of the fourth control register.
    input wire logic sw_int_valid,                            // Software interrupt instruction executed.
    input wire logic [7:0] sw_int_vector,                     // Its vector operand.
    input wire logic [IP_W-1:0] sw_int_next_ip,               // Pointer of the instruction after it.
    input wire logic external_interrupt_request,              // External or controller request, level.
    input wire logic [7:0] ext_int_vector,                    // Vector of the external request.
    input wire logic retire_idle,                             // All previous instructions have committed.
    input wire logic [IP_W-1:0] retire_next_ip,               // Pointer after the last committed instruction.
    output logic [5:0] flags_q,                               // Sticky condition flags.
    output logic busy_q,                                      // Waiting for result conditions.
    output logic op_done_q,                                   // Operation finished with default results.
    output logic simd_fault_q,                                // SIMD floating-point fault pulse.
    output logic invalid_opcode_fault_q,                      // Invalid-opcode fault pulse.
    output logic [IP_W-1:0] fault_ip_q,                       // Saved pointer of the faulting instruction.
    output logic push_error_code_q,                           // Error code push request, always low here.
    output logic int_taken_q,                                 // User interrupt dispatched pulse.
    output logic ext_int_ack_q,                               // External request accepted pulse.
    output logic [7:0] int_vector_q,                          // Dispatched vector.
    output logic [IP_W-1:0] int_return_ip_q                   // Saved return pointer for the interrupt.
);

    // ------------------------------------------------------------------
    // Per sub-operand evaluation.
    // ------------------------------------------------------------------

    // Walks the pre-computation levels from highest to lowest priority; an unmasked hit stops the walk.
    function automatic sfeu_pkg::sfeu_eval_t pre_eval(input sfeu_pkg::sfeu_pre_t c, input logic [5:0] m);
        sfeu_pkg::sfeu_eval_t r;
        r = '0;
        // Signalling NaN invalid is the top level.
        if (c.snan) begin
            r.flags[sfeu_pkg::SFEU_C_INV] = 1'b1;                         // [RULE_02] [RULE_10]
            if (!m[sfeu_pkg::SFEU_C_INV]) begin
                r.fault = 1'b1;
                r.stop = 1'b1;
            end
        end
        // Quiet NaN ends the walk without any flag.
        if (!r.stop && c.qnan) begin
            r.stop = 1'b1;                                                // [RULE_11]
        end
        // Other invalid or divide-by-zero share the third level; invalid wins and divide-by-zero is then not checked.
        if (!r.stop && c.inval) begin
            r.flags[sfeu_pkg::SFEU_C_INV] = 1'b1;                         // [RULE_12]
            if (!m[sfeu_pkg::SFEU_C_INV]) begin
                r.fault = 1'b1;
                r.stop = 1'b1;
            end
        end else if (!r.stop && c.divz) begin
            r.flags[sfeu_pkg::SFEU_C_DIVZ] = 1'b1;                        // [RULE_02]
            if (!m[sfeu_pkg::SFEU_C_DIVZ]) begin
                r.fault = 1'b1;
                r.stop = 1'b1;
            end
        end
        // Denormal operand is the fourth level.
        if (!r.stop && c.denorm) begin
            r.flags[sfeu_pkg::SFEU_C_DEN] = 1'b1;                         // [RULE_02] [RULE_12]
            if (!m[sfeu_pkg::SFEU_C_DEN]) begin
                r.fault = 1'b1;
                r.stop = 1'b1;
            end
        end
        return r;
    endfunction

    // Walks the post-computation levels: overflow or underflow, then inexact.
    function automatic sfeu_pkg::sfeu_eval_t post_eval(input sfeu_pkg::sfeu_post_t c, input logic [5:0] m);
        sfeu_pkg::sfeu_eval_t r;
        r = '0;
        // Overflow and underflow share the fifth level.
        if (c.ovf) begin
            r.flags[sfeu_pkg::SFEU_C_OVF] = 1'b1;                         // [RULE_03]
            if (!m[sfeu_pkg::SFEU_C_OVF]) begin
                r.fault = 1'b1;
                r.stop = 1'b1;
            end
        end else if (c.unf) begin
            r.flags[sfeu_pkg::SFEU_C_UNF] = 1'b1;                         // [RULE_03]
            if (!m[sfeu_pkg::SFEU_C_UNF]) begin
                r.fault = 1'b1;
                r.stop = 1'b1;
            end
        end
        // Inexact is reached only when nothing above it faulted.
        if (!r.stop && c.inex) begin
            r.flags[sfeu_pkg::SFEU_C_INEX] = 1'b1;                        // [RULE_10] [RULE_12]
            if (!m[sfeu_pkg::SFEU_C_INEX]) begin
                r.fault = 1'b1;
                r.stop = 1'b1;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    sfeu_pkg::sfeu_state_t state_q;                   // Sequencer state.
    sfeu_pkg::sfeu_state_t state_d;                   // Its next value.
    logic [LANES-1:0] live_q;                         // Sub-operands still open for result conditions.
    logic [LANES-1:0] live_d;                         // Their next value.
    logic [IP_W-1:0] ip_q;                            // Pointer of the operation in flight.
    logic [IP_W-1:0] ip_d;                            // Its next value.
    logic [5:0] flags_d;                              // Next sticky flags.
    logic busy_d;                                     // Next busy indication.
    logic op_done_d;                                  // Next completion pulse.
    logic simd_fault_d;                               // Next SIMD fault pulse.
    logic invalid_opcode_fault_d;                     // Next invalid-opcode pulse.
    logic [IP_W-1:0] fault_ip_d;                      // Next saved fault pointer.
    logic int_taken_d;                                // Next dispatch pulse.
    logic ext_int_ack_d;                              // Next external accept pulse.
    logic [7:0] int_vector_d;                         // Next dispatched vector.
    logic [IP_W-1:0] int_return_ip_d;                 // Next return pointer.

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------

    // Evaluates conditions, raises faults and chooses user interrupts for dispatch.
    always_comb begin
        logic [5:0] set_v;
        logic fault_v;
        logic user_sw;
        logic user_ext;
        sfeu_pkg::sfeu_eval_t e;
        set_v = '0;
        fault_v = 1'b0;
        user_sw = 1'b0;
        user_ext = 1'b0;
        e = '0;
        state_d = state_q;
        live_d = live_q;
        ip_d = ip_q;
        op_done_d = 1'b0;
        fault_ip_d = fault_ip_q;
        int_taken_d = 1'b0;
        ext_int_ack_d = 1'b0;
        int_vector_d = int_vector_q;
        int_return_ip_d = int_return_ip_q;
        case (state_q)
            sfeu_pkg::SFEU_ST_IDLE: begin
                // A new operation is judged on its operands only.
                if (op_valid) begin
                    ip_d = op_ip;
                    for (int i = 0; i < LANES; i++) begin
                        live_d[i] = 1'b0;
                        if (op_four_lanes || (i < sfeu_pkg::SFEU_LANES_NARROW)) begin
                            e = pre_eval(op_pre[i], mask_bits);           // [RULE_09]
                            set_v = set_v | e.flags;                      // [RULE_09]
                            fault_v = fault_v | e.fault;
                            live_d[i] = !e.stop;
                        end
                    end
                    // An unmasked operand condition ends the operation now, else wait for the result.
                    if (fault_v) begin
                        fault_ip_d = op_ip;                               // [RULE_07] [RULE_13]
                    end else begin
                        state_d = sfeu_pkg::SFEU_ST_POST;                 // [RULE_03]
                    end
                end
            end
            sfeu_pkg::SFEU_ST_POST: begin
                // Result conditions count only for sub-operands that were not stopped.
                if (res_valid) begin
                    for (int i = 0; i < LANES; i++) begin
                        if (live_q[i]) begin
                            e = post_eval(res_post[i], mask_bits);        // [RULE_03] [RULE_09]
                            set_v = set_v | e.flags;
                            fault_v = fault_v | e.fault;
                        end
                    end
                    if (fault_v) begin
                        fault_ip_d = ip_q;                                // [RULE_07] [RULE_13]
                    end else begin
                        op_done_d = 1'b1;                                 // [RULE_04]
                    end
                    live_d = '0;
                    state_d = sfeu_pkg::SFEU_ST_IDLE;
                end
            end
            default: begin
                state_d = sfeu_pkg::SFEU_ST_IDLE;
            end
        endcase
        // Faults come only from a detection event, never from a change of mask bits.
        simd_fault_d = fault_v && os_simd_fault_support;                  // [RULE_05] [RULE_08]
        invalid_opcode_fault_d = fault_v && !os_simd_fault_support;       // [RULE_06]
        // Hardware sets win over a software clear in the same cycle.
        flags_d = (flags_q & ~flag_clear) | set_v;                        // [RULE_01] [RULE_04] [RULE_17]
        busy_d = (state_d == sfeu_pkg::SFEU_ST_POST);
        // Only vectors in the user range are dispatched here.
        user_sw = sw_int_valid && (sw_int_vector >= sfeu_pkg::SFEU_USER_VEC_MIN)
            && (sw_int_vector <= sfeu_pkg::SFEU_USER_VEC_MAX);            // [RULE_14]
        user_ext = external_interrupt_request && (ext_int_vector >= sfeu_pkg::SFEU_USER_VEC_MIN)
            && (ext_int_vector <= sfeu_pkg::SFEU_USER_VEC_MAX);           // [RULE_14]
        if (user_sw) begin
            // The software instruction returns to the one after itself.
            int_taken_d = 1'b1;
            int_vector_d = sw_int_vector;
            int_return_ip_d = sw_int_next_ip;                             // [RULE_15]
        end else if (user_ext && retire_idle && !op_valid && !fault_v
            && (state_q == sfeu_pkg::SFEU_ST_IDLE)) begin
            // External requests wait until nothing is in flight and everything has committed.
            int_taken_d = 1'b1;                                           // [RULE_16]
            ext_int_ack_d = 1'b1;
            int_vector_d = ext_int_vector;
            int_return_ip_d = retire_next_ip;                             // [RULE_15]
        end
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------

    // Registers every next value; reset returns the unit to idle with clear flags.
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= sfeu_pkg::SFEU_ST_IDLE;
            live_q <= '0;
            ip_q <= '0;
            flags_q <= sfeu_pkg::SFEU_FLAGS_RST;
            busy_q <= 1'b0;
            op_done_q <= 1'b0;
            simd_fault_q <= 1'b0;
            invalid_opcode_fault_q <= 1'b0;
            fault_ip_q <= '0;
            push_error_code_q <= 1'b0;
            int_taken_q <= 1'b0;
            ext_int_ack_q <= 1'b0;
            int_vector_q <= 8'h00;
            int_return_ip_q <= '0;
        end else begin
            state_q <= state_d;
            live_q <= live_d;
            ip_q <= ip_d;
            flags_q <= flags_d;
            busy_q <= busy_d;
            op_done_q <= op_done_d;
            simd_fault_q <= simd_fault_d;
            invalid_opcode_fault_q <= invalid_opcode_fault_d;
            fault_ip_q <= fault_ip_d;
            push_error_code_q <= 1'b0;                                    // [RULE_13]
            int_taken_q <= int_taken_d;
            ext_int_ack_q <= ext_int_ack_d;
            int_vector_q <= int_vector_d;
            int_return_ip_q <= int_return_ip_d;
        end
    end

endmodule

`default_nettype wire

// [sfeu_pkg.sv]
// Package for the packed floating-point exception unit: condition indices, vector bounds and carrier types.
// Assumes it is compiled before the unit that uses it; nothing here holds state.
package sfeu_pkg;

    // ------------------------------------------------------------------
    // Condition indices in the flag and mask vectors.
    // ------------------------------------------------------------------
    localparam int unsigned SFEU_NCOND = 6;
    localparam int unsigned SFEU_C_INV = 0;
    localparam int unsigned SFEU_C_DIVZ = 1;
    localparam int unsigned SFEU_C_DEN = 2;
    localparam int unsigned SFEU_C_OVF = 3;
    localparam int unsigned SFEU_C_UNF = 4;
    localparam int unsigned SFEU_C_INEX = 5;

    // ------------------------------------------------------------------
    // Reset values, lane counts and user vector range.
    // ------------------------------------------------------------------
    localparam logic [5:0] SFEU_FLAGS_RST = 6'h00;
    localparam int unsigned SFEU_LANES_NARROW = 2;
    localparam logic [7:0] SFEU_USER_VEC_MIN = 8'h20;
    localparam logic [7:0] SFEU_USER_VEC_MAX = 8'hFF;

    // Pre-computation conditions of one sub-operand, taken from the operands.
    typedef struct packed {
        logic snan;
        logic qnan;
        logic inval;
        logic divz;
        logic denorm;
    } sfeu_pre_t;

    // Post-computation conditions of one sub-operand, taken from the result.
    typedef struct packed {
        logic ovf;
        logic unf;
        logic inex;
    } sfeu_post_t;

    // Outcome of evaluating one sub-operand.
    typedef struct packed {
        logic stop;
        logic fault;
        logic [5:0] flags;
    } sfeu_eval_t;

    // Sequencer states.
    typedef enum logic {
        SFEU_ST_IDLE,
        SFEU_ST_POST
    } sfeu_state_t;

endpackage

// [sfeu_monitor.sv]
// Checker for the packed floating-point exception unit, attached by bind.
// Assumes only the unit's ports: one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module sfeu_monitor #(parameter int unsigned IP_W = 32, parameter int unsigned LANES = 4) (
    input wire logic clock,
    input wire logic srst,
    input wire logic op_valid,
    input wire logic [IP_W-1:0] op_ip,
    input wire logic busy_q,
    input wire logic res_valid,
    input wire logic [5:0] flags_q,
    input wire logic [5:0] flag_clear,
    input wire logic os_simd_fault_support,
    input wire logic simd_fault_q,
    input wire logic invalid_opcode_fault_q,
    input wire logic [IP_W-1:0] fault_ip_q,
    input wire logic push_error_code_q,
    input wire logic op_done_q,
    input wire logic sw_int_valid,
    input wire logic [7:0] sw_int_vector,
    input wire logic [IP_W-1:0] sw_int_next_ip,
    input wire logic retire_idle,
    input wire logic [IP_W-1:0] retire_next_ip,
    input wire logic int_taken_q,
    input wire logic ext_int_ack_q,
    input wire logic [7:0] int_vector_q,
    input wire logic [IP_W-1:0] int_return_ip_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic [IP_W-1:0] ip_h;  // Pointer of the operation last taken.
    // Tracks the pointer of each accepted operation.
    always_ff @(posedge clock) begin
        if (op_valid && !busy_q) begin
            ip_h <= op_ip;
        end
    end
    a_fault_os_sel: assert property (simd_fault_q |-> $past(os_simd_fault_support))
        else $error("simd fault without support");
    a_ud_os_sel: assert property (invalid_opcode_fault_q |-> !$past(os_simd_fault_support))
        else $error("ud with support");
    a_fault_cause: assert property ((simd_fault_q || invalid_opcode_fault_q) |->
        $past(op_valid && !busy_q) || $past(res_valid && busy_q)) else $error("fault without op");
    a_fault_ptr: assert property ((simd_fault_q || invalid_opcode_fault_q) |->
        fault_ip_q == ip_h && !op_done_q) else $error("fault pointer wrong");
    a_no_errcode: assert property (!push_error_code_q) else $error("error code pushed");
    a_flags_sticky: assert property (!$past(srst) |->
        ($past(flags_q) & ~$past(flag_clear) & ~flags_q) == 6'h00) else $error("flag lost");
    a_done_cause: assert property (op_done_q |-> $past(res_valid && busy_q))
        else $error("done without result");
    a_sw_taken: assert property (sw_int_valid && sw_int_vector >= 8'h20 |=>
        int_taken_q && !ext_int_ack_q && int_return_ip_q == $past(sw_int_next_ip)) else $error("sw interrupt wrong");
    a_user_range: assert property (int_taken_q |-> int_vector_q >= 8'h20)
        else $error("vector below user range");
    a_ext_commit: assert property (ext_int_ack_q |->
        $past(retire_idle) && int_taken_q && int_return_ip_q == $past(retire_next_ip)) else $error("ext taken early");
    c_done: cover property (op_done_q);
    c_simd: cover property (simd_fault_q);
    c_ud: cover property (invalid_opcode_fault_q);
    c_ext: cover property (ext_int_ack_q);
endmodule
bind simd_fp_exception_unit sfeu_monitor #(.IP_W(IP_W), .LANES(LANES)) u_sfeu_monitor (.*);
`default_nettype wire

// [sfeu_datapath_model.sv]
// Datapath stand-in: answers each waiting operation with result conditions after a set delay.
// Assumes busy_q of the unit marks the wait for result conditions.
`timescale 1ns/10ps
`default_nettype none
module sfeu_datapath_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic busy_q,
    input wire logic [3:0] res_delay,
    input wire logic [11:0] post_in,
    output logic res_valid,
    output var sfeu_pkg::sfeu_post_t [3:0] res_post
);
    logic [3:0] cnt_q;  // Wait cycles so far.
    logic sent_q;  // The answer went out.
    // One answer per wait; outside it the lines carry the inverted value.
    always_comb begin
        res_valid = busy_q && !sent_q && (cnt_q == res_delay);
        res_post = res_valid ? post_in : ~post_in;
    end
    // Counts the wait and remembers the answer.
    always_ff @(posedge clock) begin
        if (srst || !busy_q) begin
            cnt_q <= 4'h0;
            sent_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            sent_q <= sent_q | res_valid;
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the packed floating-point exception unit.
// Assumes the package, the unit, the datapath stand-in and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock, srst, op_valid, op_four_lanes, res_valid, os_simd_fault_support, sw_int_valid;
    logic external_interrupt_request, retire_idle, busy_q, op_done_q, simd_fault_q, invalid_opcode_fault_q;
    logic push_error_code_q, int_taken_q, ext_int_ack_q;
    sfeu_pkg::sfeu_pre_t [3:0] op_pre;
    sfeu_pkg::sfeu_post_t [3:0] res_post;
    logic [11:0] post_in;
    logic [3:0] res_delay;
    logic [5:0] mask_bits, flag_clear, flags_q;
    logic [7:0] sw_int_vector, ext_int_vector, int_vector_q;
    logic [31:0] op_ip, sw_int_next_ip, retire_next_ip, fault_ip_q, int_return_ip_q;
    int error_cnt = 0;
    int checks = 0;
    simd_fp_exception_unit u_simd_fp_exception_unit (.*);
    sfeu_datapath_model u_sfeu_datapath_model (.*);
    // Free-running core clock.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Moves to just after the next rising edge.
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Clears all flags, issues one operation, waits for its outcome and judges it.
    task automatic run_op(input logic [19:0] pre, input logic four, input logic [11:0] post, input logic [5:0] msk,
                          input logic os, input logic [3:0] dly, input logic [5:0] ef, input logic [2:0] ek);
        int n;
        flag_clear = 6'h3F;
        step();
        flag_clear = 6'h00;
        op_pre = pre;
        op_four_lanes = four;
        post_in = post;
        mask_bits = msk;
        os_simd_fault_support = os;
        res_delay = dly;
        op_ip = op_ip + 32'h4;
        op_valid = 1'b1;
        step();
        op_valid = 1'b0;
        n = 0;
        while (op_done_q !== 1'b1 && simd_fault_q !== 1'b1 && invalid_opcode_fault_q !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        chk("outcome", {29'h0, ek}, {29'h0, invalid_opcode_fault_q, simd_fault_q, op_done_q});
        chk("flags", {26'h0, ef}, {26'h0, flags_q});
        chk("busy", 32'h0, {31'h0, busy_q});
        if (ek != 3'h1) begin
            chk("fault_ip", op_ip, fault_ip_q);
        end
        step();
    endtask
    // Masked conditions across lanes, pre and post, lower ones also flagged.
    task automatic t_masked();
        run_op({5'h00, 5'h00, 5'h01, 5'h02}, 1'b1, {3'h0, 3'h7, 3'h0, 3'h0},
            6'h3F, 1'b1, 4'h3, 6'h2E, 3'h1);
        $display("test masked done");
    endtask
    // Quiet NaN with divide by zero and inexact: nothing flagged.
    task automatic t_qnan();
        run_op({5'h00, 5'h00, 5'h00, 5'h0A}, 1'b1, {3'h0, 3'h0, 3'h0, 3'h1},
            6'h3F, 1'b1, 4'h0, 6'h00, 3'h1);
        $display("test qnan done");
    endtask
    // Unmasked signalling NaN with support: fault at once, lower condition dropped.
    task automatic t_pre_fault();
        run_op({5'h00, 5'h00, 5'h11, 5'h02}, 1'b1, {3'h0, 3'h0, 3'h0, 3'h4},
            6'h3E, 1'b1, 4'h0, 6'h03, 3'h2);
        $display("test pre fault done");
    endtask
    // Unmasked overflow without support: invalid opcode after the result.
    task automatic t_post_ud();
        run_op({5'h00, 5'h00, 5'h00, 5'h01}, 1'b1, {3'h5, 3'h0, 3'h0, 3'h0},
            6'h37, 1'b0, 4'h2, 6'h0C, 3'h4);
        $display("test post ud done");
    endtask
    // Two-lane operation ignores the upper lanes.
    task automatic t_narrow();
        run_op({5'h00, 5'h02, 5'h01, 5'h00}, 1'b0, {3'h4, 3'h0, 3'h0, 3'h0},
            6'h3F, 1'b1, 4'h1, 6'h04, 3'h1);
        $display("test narrow done");
    endtask
    // Unmasking a set flag faults nothing; flags hold until cleared.
    task automatic t_unmask();
        mask_bits = 6'h00;
        repeat (4) begin
            step();
            chk("faults", 32'h0, {30'h0, simd_fault_q, invalid_opcode_fault_q});
        end
        chk("held flags", 32'h4, {26'h0, flags_q});
        flag_clear = 6'h04;
        step();
        flag_clear = 6'h00;
        step();
        chk("cleared flags", 32'h0, {26'h0, flags_q});
        $display("test unmask done");
    endtask
    // Software and external user interrupts, low vector refused, commit wait.
    task automatic t_user_int();
        int n;
        sw_int_vector = 8'h80;
        sw_int_next_ip = 32'h1004;
        sw_int_valid = 1'b1;
        step();
        chk("sw taken", 32'h1, {31'h0, int_taken_q});
        chk("sw vector", 32'h80, {24'h0, int_vector_q});
        chk("sw ret ip", 32'h1004, int_return_ip_q);
        // The strobe stays up; only the vector changes for the second instruction.
        sw_int_vector = 8'h1F;
        step();
        sw_int_valid = 1'b0;
        chk("low vector", 32'h0, {31'h0, int_taken_q});
        retire_idle = 1'b0;
        retire_next_ip = 32'h2000;
        ext_int_vector = 8'hFF;
        external_interrupt_request = 1'b1;
        repeat (3) begin
            step();
            chk("ext held off", 32'h0, {31'h0, ext_int_ack_q});
        end
        retire_idle = 1'b1;
        n = 0;
        while (ext_int_ack_q !== 1'b1 && n < 10) begin
            step();
            n++;
        end
        external_interrupt_request = 1'b0;
        chk("ext ack", 32'h1, {31'h0, ext_int_ack_q});
        chk("ext taken", 32'h1, {31'h0, int_taken_q});
        chk("ext vector", 32'hFF, {24'h0, int_vector_q});
        chk("ext ret ip", 32'h2000, int_return_ip_q);
        $display("test user int done");
    endtask
    // Cuts a hang short.
    initial begin
        #8000;
        error_cnt++;
        close_out();
    end
    // Reset, then the tests in turn.
    initial begin
        {srst, op_valid, op_four_lanes, os_simd_fault_support, sw_int_valid, external_interrupt_request} = 6'h21;
        {op_pre, post_in, res_delay, mask_bits, flag_clear} = '0;
        {sw_int_vector, ext_int_vector, op_ip, sw_int_next_ip, retire_next_ip} = '0;
        retire_idle = 1'b1;
        repeat (5) step();
        srst = 1'b0;
        step();
        t_masked();
        t_qnan();
        t_pre_fault();
        t_post_ud();
        t_narrow();
        t_unmask();
        t_user_int();
        close_out();
    end
endmodule
`default_nettype wire
